// ---- hdl/floppy_command_parameter_decode.sv ----
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/10ps
module floppy_command_parameter_decode
    import fdc_param_pkg::*;
#(
    parameter logic [7:0] GAP2_NORMAL = 8'h10,
    parameter int         STEP_WAIT   = STEP_CYCLES
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        byte_tick,
    input  wire logic [7:0]  disk_rd_data,
    input  wire logic [7:0]  host_wr_data,
    output logic             host_rd_valid,
    output logic [7:0]       host_rd_data,
    output logic             host_wr_req,
    output logic             disk_wr_valid,
    output logic [7:0]       disk_wr_data,
    output logic             drive_enable,
    output logic             step_pulse,
    output logic             step_dir,
    output logic             density_dd,
    output logic             fifo_enable,
    output logic [7:0]       gap2_len,
    output logic [7:0]       gap3_len,
    output logic             busy
);
    // ***************************************************
    // Elaboration checks
    // ***************************************************
    if (STEP_WAIT < 1 || STEP_WAIT > 65535) begin : g_bad_step
        $error("STEP_WAIT out of range");
    end

    // ***************************************************
    // Bus slave
    // ***************************************************
    logic        a_valid;   // Data phase pending
    logic        a_write;   // Pending phase is a write
    logic [7:0]  a_ofs;     // Pending register offset
    logic [31:0] ctrl;      // Control shadow
    logic [31:0] size_r;    // Size shadow
    logic [31:0] track_r;   // Track shadow
    logic        refused;   // Last start named an absent drive
    logic [15:0] crc;       // CRC of last sector
    logic [31:0] new_ctrl;  // Control value being written
    logic        wr_ctrl;   // Control write in data phase
    logic        start_req; // Start bit written
    exec_state_t state;     // Execution state
    logic [7:0]  cur_cyl;   // Cylinder under the head
    logic [7:0]  sec_num;   // Sector in progress

    assign new_ctrl  = hwdata & CTRL_MASK;
    assign wr_ctrl   = a_valid && a_write && a_ofs == OFS_CTRL;
    assign start_req = wr_ctrl && hwdata[B_START];

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_valid <= 1'b0;
            a_write <= 1'b0;
            a_ofs   <= OFS_NONE;
        end else if (hready) begin
            a_valid <= hsel && htrans[1];
            a_write <= hwrite;
            a_ofs   <= haddr[31:8] == 24'h000000 ? haddr[7:0] : OFS_NONE;
        end
    end

    // Reads take one wait state, writes none
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
            hresp     <= 1'b0;
        end
    end

    // Read data, unmapped offsets read zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (!hreadyout) begin
            unique case (a_ofs)
                OFS_CTRL:   hrdata <= ctrl;
                OFS_SIZE:   hrdata <= size_r;
                OFS_TRACK:  hrdata <= track_r;
                OFS_STATUS: hrdata <= {8'h00, sec_num, cur_cyl, 5'h00,
                                       state == ST_SEEK, refused, busy};
                OFS_CRC:    hrdata <= {16'h0000, crc};
                default:    hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Shadow registers, writable at any time
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl    <= CTRL_RST;
            size_r  <= SIZE_RST;
            track_r <= TRACK_RST;
        end else if (a_valid && a_write) begin
            if (a_ofs == OFS_CTRL) begin
                ctrl <= new_ctrl;
            end
            if (a_ofs == OFS_SIZE) begin
                size_r <= hwdata & SIZE_MASK;
            end
            if (a_ofs == OFS_TRACK) begin
                track_r <= hwdata;
            end
        end
    end

    // ***************************************************
    // Latched command parameters
    // ***************************************************
    logic        x_dir;     // Relative step direction
    logic        x_ec;      // Count flag
    logic        x_fifo_n;  // FIFO disable, active low enable
    logic        x_dd;      // Double density select
    logic        x_perp;    // Perpendicular recording
    logic        x_write;   // Write command
    logic        x_verify;  // Verify command
    logic        x_rel;     // Relative seek command
    logic [7:0]  x_code;    // Sector size code
    logic [7:0]  x_short;   // Short length or sector count
    logic [7:0]  x_eot;     // Last sector number
    logic [7:0]  x_gap2;    // Gap 2 adjust
    logic [7:0]  x_gap3;    // Gap 3 length
    logic        start_ok;  // Start accepted this cycle

    assign start_ok = start_req && state == ST_IDLE
                      && new_ctrl[B_DRIVE+:2] == 2'b00;

    // Parameters change only when a command is accepted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            x_dir    <= 1'b0;
            x_ec     <= 1'b0;
            x_fifo_n <= CTRL_RST[B_FIFO_DIS_N];
            x_dd     <= 1'b0;
            x_perp   <= 1'b0;
            x_write  <= 1'b0;
            x_verify <= 1'b0;
            x_rel    <= 1'b0;
            x_code   <= 8'h00;
            x_short  <= 8'h00;
            x_eot    <= 8'h00;
            x_gap2   <= 8'h00;
            x_gap3   <= 8'h00;
        end else if (start_ok) begin
            x_dir    <= new_ctrl[B_STEP_DIR];
            x_ec     <= new_ctrl[B_COUNT_EN];
            x_fifo_n <= new_ctrl[B_FIFO_DIS_N];
            x_dd     <= new_ctrl[B_DENSITY];
            x_perp   <= new_ctrl[B_PERP];
            x_write  <= new_ctrl[B_WRITE];
            x_verify <= new_ctrl[B_VERIFY];
            x_rel    <= new_ctrl[B_RELATIVE];
            x_code   <= size_r[F_CODE+:8];
            x_short  <= size_r[F_SHORT+:8];
            x_eot    <= track_r[F_EOT+:8];
            x_gap2   <= track_r[F_GAP2+:8];
            x_gap3   <= track_r[F_GAP3+:8];
        end
    end

    // ***************************************************
    // Sector lengths
    // ***************************************************
    logic [2:0]  code_c;   // Size code, clamped to the largest
    logic [14:0] sec_len;  // Physical sector bytes
    logic [14:0] xfer_len; // Bytes passed to or from host
    logic        cnt_mode; // Verify with count flag counts sectors

    assign code_c   = x_code > MAX_SIZE_CODE ? 3'(MAX_SIZE_CODE) : x_code[2:0];
    assign sec_len  = BASE_SECTOR_BYTES << code_c;
    assign cnt_mode = x_verify && x_ec;

    // Verify moves nothing; code zero honours the short length
    always_comb begin
        if (x_verify) begin
            xfer_len = 15'h0000;
        end else if (x_code == 8'h00) begin
            xfer_len = {7'h00, x_short} < BASE_SECTOR_BYTES ? {7'h00, x_short}
                                                            : BASE_SECTOR_BYTES;
        end else begin
            xfer_len = sec_len;
        end
    end

    // ***************************************************
    // Execution sequencer
    // ***************************************************
    logic [7:0]  steps;     // Steps still to take
    logic        dir_in;    // Stepping toward the spindle
    logic [15:0] step_tmr;  // Wait before next step
    logic [7:0]  sec_cnt;   // Sectors finished this command
    logic        sec_start; // Opens the next sector
    logic        sec_done;  // Sector finished
    logic        last_sec;  // Sector just finished ends the command
    logic [7:0]  tgt_cyl;   // Cylinder named by the command
    logic        need_seek; // Implied seek wanted

    assign tgt_cyl   = track_r[F_CYL+:8];
    assign need_seek = new_ctrl[B_SEEK_EN] && new_ctrl[B_HAS_CYL]
                       && tgt_cyl != cur_cyl;
    assign last_sec  = cnt_mode ? sec_cnt + 8'h01 >= x_short
                                : sec_num == x_eot;

    // Seek stepping and multi-sector walk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= ST_IDLE;
            cur_cyl   <= 8'h00;
            steps     <= 8'h00;
            dir_in    <= 1'b0;
            step_tmr  <= 16'h0000;
            sec_num   <= 8'h00;
            sec_cnt   <= 8'h00;
            sec_start <= 1'b0;
            refused   <= 1'b0;
        end else begin
            sec_start <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (start_req) begin
                        refused <= !start_ok;
                    end
                    if (start_ok) begin
                        sec_num  <= size_r[F_FIRST+:8];
                        sec_cnt  <= 8'h00;
                        step_tmr <= 16'(STEP_WAIT - 1);
                        if (new_ctrl[B_RELATIVE]) begin
                            steps  <= tgt_cyl;
                            dir_in <= new_ctrl[B_STEP_DIR];
                            state  <= tgt_cyl == 8'h00 ? ST_IDLE : ST_SEEK;
                        end else if (need_seek) begin
                            steps  <= tgt_cyl > cur_cyl ? tgt_cyl - cur_cyl
                                                        : cur_cyl - tgt_cyl;
                            dir_in <= tgt_cyl > cur_cyl;
                            state  <= ST_SEEK;
                        end else begin
                            sec_start <= 1'b1;
                            state     <= ST_XFER;
                        end
                    end
                end
                ST_SEEK: begin
                    if (step_tmr != 16'h0000) begin
                        step_tmr <= step_tmr - 16'h0001;
                    end else begin
                        step_tmr <= 16'(STEP_WAIT - 1);
                        steps    <= steps - 8'h01;
                        cur_cyl  <= dir_in ? cur_cyl + 8'h01 : cur_cyl - 8'h01;
                        if (steps == 8'h01) begin
                            sec_start <= !x_rel;
                            state     <= x_rel ? ST_IDLE : ST_XFER;
                        end
                    end
                end
                ST_XFER: begin
                    if (sec_done) begin
                        if (last_sec) begin
                            state <= ST_IDLE;
                        end else begin
                            sec_num   <= sec_num + 8'h01;
                            sec_cnt   <= sec_cnt + 8'h01;
                            sec_start <= 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    // ***************************************************
    // Drive-side outputs
    // ***************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_enable <= 1'b0;
            step_pulse   <= 1'b0;
            step_dir     <= 1'b0;
            density_dd   <= 1'b0;
            fifo_enable  <= 1'b0;
            gap2_len     <= GAP2_NORMAL;
            gap3_len     <= 8'h00;
            busy         <= 1'b0;
        end else begin
            drive_enable <= state != ST_IDLE;
            step_pulse   <= state == ST_SEEK && step_tmr == 16'h0000;
            step_dir     <= dir_in;
            density_dd   <= x_dd;
            fifo_enable  <= !x_fifo_n;
            gap2_len     <= x_perp ? x_gap2 : GAP2_NORMAL;
            gap3_len     <= x_gap3;
            busy         <= state != ST_IDLE;
        end
    end

    // Byte path of the current sector
    sector_byte_path u_path (
        .hclk          (hclk),
        .hresetn       (hresetn),
        .start         (sec_start),
        .write_mode    (x_write),
        .sec_len       (sec_len),
        .xfer_len      (xfer_len),
        .byte_tick     (byte_tick),
        .rd_byte       (disk_rd_data),
        .wr_byte       (host_wr_data),
        .host_rd_valid (host_rd_valid),
        .host_rd_data  (host_rd_data),
        .host_wr_req   (host_wr_req),
        .disk_wr_valid (disk_wr_valid),
        .disk_wr_data  (disk_wr_data),
        .done          (sec_done),
        .crc           (crc)
    );

    // ***************************************************
    // Checks
    // ***************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_rel_step_dir: assert property (
        start_ok && new_ctrl[B_RELATIVE] && tgt_cyl != 8'h00
        |-> ##2 step_dir == $past(new_ctrl[B_STEP_DIR], 2))
        else $error("relative step direction wrong");
    chk_drive_refuse: assert property (
        start_req && state == ST_IDLE && new_ctrl[B_DRIVE+:2] != 2'b00
        |-> ##1 state == ST_IDLE && refused)
        else $error("absent drive not refused");
    chk_fifo_setting: assert property (
        start_ok |-> ##2 fifo_enable == !$past(new_ctrl[B_FIFO_DIS_N], 2))
        else $error("fifo enable not from latched setting");
    chk_implied_seek: assert property (
        start_ok && !new_ctrl[B_RELATIVE]
        |-> ##1 (state == ST_SEEK) == $past(need_seek))
        else $error("implied seek decision wrong");
    chk_last_sector: assert property (
        state == ST_XFER && sec_done && !cnt_mode && sec_num == x_eot
        |-> ##1 state == ST_IDLE)
        else $error("transfer ran past last sector");
    chk_gap2_perp: assert property (
        busy && !x_perp |-> gap2_len == GAP2_NORMAL)
        else $error("gap 2 altered outside perpendicular mode");
    chk_gap3_len: assert property (
        busy && $past(busy) |-> gap3_len == $past(x_gap3))
        else $error("gap 3 length not from parameter");
    chk_density_sel: assert property (
        busy && $past(busy) |-> density_dd == $past(x_dd))
        else $error("density select wrong");
    chk_params_held: assert property (
        state != ST_IDLE && $past(state) != ST_IDLE
        |-> $stable(x_code) && $stable(x_short) && $stable(x_eot) && $stable(x_gap3))
        else $error("parameters changed during execution");
endmodule

// ---- hdl/fdc_param_pkg.sv ----
// Functional notes
// - Relative seek: 0 steps out, 1 steps in
// - Only drive code 00 is served
// - Size code zero: short length sets transfer
// - Short read: rest read, not delivered
// - Short write: rest of sector zero-filled
// - CRC covers whole physical sector
// - Count flag: verify length becomes sector count
// - Active-low FIFO enable, disabled by default
// - Implied seek before cylinder commands if enabled
// - Last sector number ends multi-sector transfer
// - Gap 2 adjust only in perpendicular mode
// - Intersector spacer sets gap 3
// - Sector length 128 times two to code
// - Density select: one double, zero single
package fdc_param_pkg;
    // ***************************************************
    // Register map
    // ***************************************************
    localparam logic [7:0]  OFS_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_SIZE   = 8'h04;
    localparam logic [7:0]  OFS_TRACK  = 8'h08;
    localparam logic [7:0]  OFS_STATUS = 8'h0c;
    localparam logic [7:0]  OFS_CRC    = 8'h10;
    localparam logic [7:0]  OFS_NONE   = 8'hff;
    // Control word bit positions
    localparam int B_START = 0;
    localparam int B_STEP_DIR = 1;
    localparam int B_DRIVE = 2;
    localparam int B_COUNT_EN = 4;
    localparam int B_FIFO_DIS_N = 5;
    localparam int B_SEEK_EN = 6;
    localparam int B_DENSITY = 7;
    localparam int B_PERP = 8;
    localparam int B_WRITE = 9;
    localparam int B_HAS_CYL = 10;
    localparam int B_RELATIVE = 11;
    localparam int B_VERIFY = 12;
    // Field positions of size and track words
    localparam int F_CODE = 0;
    localparam int F_SHORT = 8;
    localparam int F_FIRST = 16;
    localparam int F_EOT = 0;
    localparam int F_GAP2 = 8;
    localparam int F_GAP3 = 16;
    localparam int F_CYL = 24;
    // Writable masks and reset values
    localparam logic [31:0] CTRL_MASK  = 32'h0000_1ffe;
    localparam logic [31:0] SIZE_MASK  = 32'h00ff_ffff;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0020;
    localparam logic [31:0] SIZE_RST   = 32'h0001_ff00;
    localparam logic [31:0] TRACK_RST  = 32'h0000_0000;
    // ***************************************************
    // Sector geometry, CRC and timing
    // ***************************************************
    localparam logic [14:0] BASE_SECTOR_BYTES = 15'h0080;
    localparam logic [7:0]  MAX_SIZE_CODE     = 8'h07;
    localparam logic [15:0] CRC_INIT          = 16'hffff;
    localparam logic [15:0] CRC_POLY          = 16'h1021;
    localparam int CLK_NS      = 8;
    localparam int STEP_NS     = 8000;
    localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;
    // Execution sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_SEEK, ST_XFER} exec_state_t;
endpackage

// ---- hdl/sector_byte_path.sv ----
`timescale 1ns/10ps
module sector_byte_path
    import fdc_param_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        start,
    input  wire logic        write_mode,
    input  wire logic [14:0] sec_len,
    input  wire logic [14:0] xfer_len,
    input  wire logic        byte_tick,
    input  wire logic [7:0]  rd_byte,
    input  wire logic [7:0]  wr_byte,
    output logic             host_rd_valid,
    output logic [7:0]       host_rd_data,
    output logic             host_wr_req,
    output logic             disk_wr_valid,
    output logic [7:0]       disk_wr_data,
    output logic             done,
    output logic [15:0]      crc
);
    // ***************************************************
    // Byte walk through one physical sector
    // ***************************************************
    logic        active;   // Sector in progress
    logic [14:0] idx;      // Byte index inside sector
    logic        in_span;  // Byte belongs to host transfer
    logic [7:0]  cur;      // Byte as it stands on disk

    // One CRC byte step, MSB first
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = r[15] ^ d[i] ? {r[14:0], 1'b0} ^ CRC_POLY : {r[14:0], 1'b0};
        end
        return r;
    endfunction

    assign in_span = idx < xfer_len;
    assign cur     = write_mode ? (in_span ? wr_byte : 8'h00) : rd_byte;

    // Index, CRC and end of sector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active <= 1'b0;
            idx    <= 15'h0000;
            crc    <= CRC_INIT;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                active <= 1'b1;
                idx    <= 15'h0000;
                crc    <= CRC_INIT;
            end else if (active && byte_tick) begin
                crc <= crc_byte(crc, cur);
                idx <= idx + 15'h0001;
                if (idx == sec_len - 15'h0001) begin
                    active <= 1'b0;
                    done   <= 1'b1;
                end
            end
        end
    end

    // Host and disk byte strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_rd_valid <= 1'b0;
            host_rd_data  <= 8'h00;
            host_wr_req   <= 1'b0;
            disk_wr_valid <= 1'b0;
            disk_wr_data  <= 8'h00;
        end else begin
            host_rd_valid <= active && byte_tick && !write_mode && in_span;
            host_rd_data  <= rd_byte;
            host_wr_req   <= active && byte_tick && write_mode && in_span;
            disk_wr_valid <= active && byte_tick && write_mode;
            disk_wr_data  <= cur;
        end
    end

    chk_short_read: assert property (@(posedge hclk) disable iff (!hresetn)
        host_rd_valid |-> $past(idx) < $past(xfer_len))
        else $error("read byte delivered beyond short length");
    chk_zero_fill: assert property (@(posedge hclk) disable iff (!hresetn)
        disk_wr_valid && $past(idx) >= $past(xfer_len) |-> disk_wr_data == 8'h00)
        else $error("sector tail not zero filled");
endmodule

// ---- sim/floppy_drive_model.sv ----
`timescale 1ns/10ps
// ***********************
// Drive and host byte source
// ***********************
module floppy_drive_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       drive_enable,
    output logic            byte_tick,
    output logic [7:0]      disk_rd_data,
    output logic [7:0]      host_wr_data
);
    logic [7:0] cnt;  // Free pattern, changes every cycle
    // Byte cell every second cycle, only while the drive is enabled
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 8'h00;
            byte_tick <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
            byte_tick <= drive_enable & ~byte_tick;
        end
    end
    assign disk_rd_data = cnt;
    assign host_wr_data = cnt | 8'h01;  // Host bytes never zero
endmodule

// ---- sim/floppy_command_parameter_decode_test.sv ----
`timescale 1ns/10ps
module floppy_command_parameter_decode_test;
    import fdc_param_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, byte_tick, hready;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0] htrans = 0;
    logic [7:0] drd, hwd, hrd, dwd, g2, g3;
    logic hrv, hwr, dwv, den, stp, sdir, dd, fen, busy, hresp;
    int fails = 0, check_count = 0, nrd = 0, nwr = 0, nz = 0, nst = 0, nin = 0, nhw = 0;
    int b[6];
    logic hrdyo;
    logic [7:0] pd;  // Disk byte offered at the previous edge
    always #4 hclk = ~hclk;
    assign hready = hrdyo;
    floppy_command_parameter_decode #(.STEP_WAIT(4)) floppy_command_parameter_decode_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hrdyo), .hresp(hresp), .byte_tick(byte_tick), .disk_rd_data(drd),
        .host_wr_data(hwd), .host_rd_valid(hrv), .host_rd_data(hrd), .host_wr_req(hwr),
        .disk_wr_valid(dwv), .disk_wr_data(dwd), .drive_enable(den), .step_pulse(stp),
        .step_dir(sdir), .density_dd(dd), .fifo_enable(fen), .gap2_len(g2), .gap3_len(g3),
        .busy(busy));
    floppy_drive_model floppy_drive_model_inst (.hclk(hclk), .hresetn(hresetn),
        .drive_enable(den), .byte_tick(byte_tick), .disk_rd_data(drd), .host_wr_data(hwd));
    // Strobe counters
    always @(posedge hclk) begin
        nrd += hrv;
        nwr += dwv;
        nz += (dwv && dwd === 8'h00);
        nst += stp;
        nin += (stp && sdir);
        nhw += hwr;
        if (hrv === 1'b1) chk("rd byte", hrd, pd);
        pd = drd;
    end
    task conclude;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // Wait until hreadyout is sampled high at a rising edge
    task rdy;
        int i;
        i = 0;
        do begin
            @(negedge hclk) q = hrdata;
            i++;
            if (i > 50) begin fails++; conclude(); end
        end while (hrdyo !== 1'b1);
        @(posedge hclk);
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
        rdy();
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        rdy();
    endtask
    // Wait for busy to reach a level within a bound
    task wbusy(input logic v, input int lim);
        int i;
        for (i = 0; busy !== v; i++) begin
            @(posedge hclk);
            if (i > lim) begin fails++; conclude(); end
        end
    endtask
    task go(input logic [31:0] c, input logic [31:0] s, input logic [31:0] t);
        bus(1, OFS_SIZE, s); bus(1, OFS_TRACK, t); bus(1, OFS_CTRL, c | 32'h1);
        wbusy(1, 20);
        b = '{nrd, nwr, nz, nst, nin, nhw};
    endtask
    task done;
        wbusy(0, 20000);
        b = '{nrd - b[0], nwr - b[1], nz - b[2], nst - b[3], nin - b[4], nhw - b[5]};
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        bus(0, OFS_CTRL, 0);
        chk("ctrl", q, 32'h20);
        bus(0, OFS_SIZE, 0);
        chk("size", q, 32'h0001ff00);
        bus(0, 8'h20, 0);
        chk("unmapped", q, 0);
        chk("fifo", fen, 0);
        chk("gap2", g2, 8'h10);
        chk("gap3", g3, 0);
        chk("hresp", hresp, 0);
        go(32'h180, 32'h0001_0200, 32'h002a_3301);
        chk("gap2", g2, 8'h33);
        chk("gap3", g3, 8'h2a);
        chk("dd", dd, 1);
        chk("fifo", fen, 1);
        chk("drive on", den, 1);
        bus(1, OFS_TRACK, 32'h0011_2201);
        repeat (2) @(posedge hclk);
        chk("held", g3, 8'h2a);
        done();
        chk("short rd", b[0], 2);
        chk("drive off", den, 0);
        go(32'h220, 32'h0001_0200, 32'h0000_3301);
        chk("gap2", g2, 8'h10);
        chk("dd", dd, 0);
        chk("fifo", fen, 0);
        done();
        chk("wr", b[1], 128);
        chk("zero", b[2], 126);
        chk("host wr", b[5], 2);
        go(32'h20, 32'h0001_ff01, 32'h0000_0003);
        done();
        chk("multi", b[0], 768);
        go(32'h460, 32'h0001_0200, 32'h0200_0001);
        done();
        chk("implied", b[3], 2);
        go(32'h420, 32'h0001_0200, 32'h0500_0001);
        done();
        chk("no seek", b[3], 0);
        go(32'h822, 32'h0001_0200, 32'h0300_0001);
        done();
        chk("in", b[4], 3);
        go(32'h820, 32'h0001_0200, 32'h0100_0001);
        done();
        chk("out", b[3] - b[4], 1);
        go(32'h1030, 32'h0001_0300, 32'h0000_0001);
        done();
        chk("verify rd", b[0], 0);
        bus(1, OFS_CTRL, 32'h25);
        repeat (4) @(posedge hclk);
        bus(0, OFS_STATUS, 0);
        chk("refuse", q[1:0], 2'b10);
        chk("cylinder", q[15:8], 8'h04);
        chk("sectors", q[23:16], 8'h03);
        conclude();
    end
endmodule
